/* acs_defines.svh */
// constants of the asynchronous serial channel
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_FACT_X1     2'b00
`define ACS_FACT_X16    2'b01
`define ACS_FACT_X32    2'b10
`define ACS_FACT_X64    2'b11
`define ACS_DIV_X1      7'h01
`define ACS_DIV_X16     7'h10
`define ACS_DIV_X32     7'h20
`define ACS_DIV_X64     7'h40
`define ACS_LEN_5       2'b00
`define ACS_LEN_7       2'b01
`define ACS_LEN_6       2'b10
`define ACS_LEN_8       2'b11
`define ACS_STOP_1      2'b01
`define ACS_STOP_15     2'b10
`define ACS_STOP_2      2'b11
`define ACS_HALVES_1    3'h2
`define ACS_HALVES_15   3'h3
`define ACS_HALVES_2    3'h4
`define ACS_ENC_NRZ     2'b00
`define ACS_TX_DEPTH    4
`define ACS_RX_DEPTH    8
`define ACS_THRESH_LVL  4
`define ACS_CHAR_W      8
`define ACS_ENTRY_W     10
`define ACS_ENT_PERR    8
`define ACS_ENT_FERR    9
`endif

/* acs_pkg.sv */
// types of the asynchronous serial channel
`default_nettype none
package acs_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} acs_tx_state_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} acs_rx_state_e;
    typedef logic [1:0] acs_sel_t;
endpackage
`default_nettype wire

/* acs_fifo_if.sv */
// push/pop bundle between the channel and its fifos
`timescale 1ns/1ps
`default_nettype none
interface acs_fifo_if #(parameter int W = 8, parameter int D = 4);
    localparam int CW = $clog2(D) + 1;
    logic          push;
    logic [W-1:0]  wdata;
    logic          full;
    logic          pop;
    logic [W-1:0]  rdata;
    logic          empty;
    logic [CW-1:0] count;
    modport store (input push, input wdata, input pop,
                   output full, output rdata, output empty, output count);
    modport user  (output push, output wdata, output pop,
                   input full, input rdata, input empty, input count);
endinterface
`default_nettype wire

/* acs_fifo.sv */
// first-in first-out store, any depth
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic mclk,
    input  wire logic reset,
    acs_fifo_if.store f
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D) + 1;
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [CW-1:0] cnt_reg;
    wire           do_push = f.push && !f.full;
    wire           do_pop  = f.pop && !f.empty;

    assign f.full  = (cnt_reg == CW'(D));
    assign f.empty = (cnt_reg == '0);
    assign f.rdata = mem[rd_reg];
    assign f.count = cnt_reg;

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_reg] <= f.wdata;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_push) begin
                wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule
`default_nettype wire

/* acs_bitclk.sv */
// bit-cell timer: mid-cell and end-of-cell strobes at the clock factor
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_bitclk (
    input  wire logic  mclk,
    input  wire logic  reset,
    input  wire logic  restart,
    input  wire logic [1:0] factor,
    output logic       mid,
    output logic       tick
);
    logic [6:0] cnt_reg;
    logic [6:0] div;

    assign div  = (factor == `ACS_FACT_X16) ? `ACS_DIV_X16 :
                  (factor == `ACS_FACT_X32) ? `ACS_DIV_X32 :
                  (factor == `ACS_FACT_X64) ? `ACS_DIV_X64 : `ACS_DIV_X1;
    assign tick = (cnt_reg == div - 7'h01);
    assign mid  = (cnt_reg == ((div >> 1) == 7'h00 ? 7'h00 : (div >> 1) - 7'h01));

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_reg <= 7'h00;
        end else if (restart || tick) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end
endmodule
`default_nettype wire

/* acs_channel.sv */
// asynchronous serial channel: tx/rx framing, fifos, status and modem pins
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_channel #(
    parameter int RX_DEPTH = `ACS_RX_DEPTH,
    parameter int TX_DEPTH = `ACS_TX_DEPTH
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [1:0] stop_sel,
    input  wire logic       parity_en,
    input  wire logic       parity_even,
    input  wire logic [1:0] clk_factor,
    input  wire logic [1:0] line_encoding,
    input  wire logic [1:0] rx_len,
    input  wire logic       rx_enable,
    input  wire logic       auto_enable,
    input  wire logic [1:0] tx_len,
    input  wire logic       tx_enable,
    input  wire logic       send_break,
    input  wire logic       rts_bit,
    input  wire logic       dtr_bit,
    input  wire logic       dtr_is_req,
    input  wire logic       tx_thresh,
    input  wire logic       rx_thresh,
    input  wire logic       parity_intr_en,
    input  wire logic       xtal_en,
    input  wire logic       tx_wr,
    input  wire logic [7:0] tx_wdata,
    input  wire logic       rx_rd,
    input  wire logic       error_reset,
    input  wire logic       rxd,
    input  wire logic       cts_pin_n,
    input  wire logic       carrier_detect_pin_n,
    input  wire logic       sync_pin_n,
    output logic            txd,
    output logic            rts_pin_n,
    output logic            dtr_req_pin_n,
    output logic            tx_space_flag,
    output logic            tx_intr_req,
    output logic            all_sent,
    output logic            rx_avail_flag,
    output logic            rx_intr_req,
    output logic [7:0]      rx_data,
    output logic            rx_framing_err,
    output logic            rx_parity_err,
    output logic            rx_overrun_err,
    output logic            special_rx_cond,
    output logic            break_flag,
    output logic            sync_hunt_flag,
    output logic            carrier_flag,
    output logic            cts_flag,
    output logic [1:0]      line_code
);
    // character length code to bit count
    function automatic logic [3:0] bits_of(input logic [1:0] code);
        case (code)
            `ACS_LEN_7: bits_of = 4'h7;
            `ACS_LEN_6: bits_of = 4'h6;
            `ACS_LEN_8: bits_of = 4'h8;
            default:    bits_of = 4'h5;
        endcase
    endfunction

    function automatic logic [7:0] low_mask(input logic [3:0] n);
        low_mask = ~(8'hff << n);
    endfunction

    acs_fifo_if #(.W(`ACS_CHAR_W), .D(TX_DEPTH)) txq ();
    acs_fifo_if #(.W(`ACS_ENTRY_W), .D(RX_DEPTH)) rxq ();

    acs_fifo #(.W(`ACS_CHAR_W), .D(TX_DEPTH)) u_txq (
        .mclk  (mclk),
        .reset (reset),
        .f     (txq)
    );
    acs_fifo #(.W(`ACS_ENTRY_W), .D(RX_DEPTH)) u_rxq (
        .mclk  (mclk),
        .reset (reset),
        .f     (rxq)
    );

    // ---------------- transmitter ----------------
    acs_pkg::acs_tx_state_e tx_state_reg;
    logic [7:0] tx_sh_reg;
    logic [3:0] tx_cnt_reg;
    logic [2:0] tx_half_reg;
    logic       tx_par_reg;
    logic       tx_mid;
    logic       tx_tick;
    wire  [3:0] tx_n      = bits_of(tx_len);
    wire        tx_go     = tx_enable && !(auto_enable && cts_pin_n);
    wire        tx_load   = (tx_state_reg == acs_pkg::TX_IDLE) && tx_go && !txq.empty;
    wire  [2:0] tx_halves = (stop_sel == `ACS_STOP_2)  ? `ACS_HALVES_2 :
                            (stop_sel == `ACS_STOP_15) ? `ACS_HALVES_15 : `ACS_HALVES_1;
    wire  [2:0] tx_half_next = tx_half_reg + {2'b00, tx_mid} + {2'b00, tx_tick};
    wire        tx_stop_done = (tx_state_reg == acs_pkg::TX_STOP) && (tx_half_next >= tx_halves);
    wire        tx_idle_now  = (tx_state_reg == acs_pkg::TX_IDLE) && !tx_load;
    // odd parity sends the inverse of the data xor
    wire        tx_par_bit = ^(txq.rdata & low_mask(tx_n)) ^ ~parity_even;

    assign txq.push  = tx_wr;
    assign txq.wdata = tx_wdata;
    assign txq.pop   = tx_load;

    acs_bitclk u_txclk (
        .mclk    (mclk),
        .reset   (reset),
        .restart (tx_load),
        .factor  (clk_factor),
        .mid     (tx_mid),
        .tick    (tx_tick)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tx_state_reg <= acs_pkg::TX_IDLE;
            tx_sh_reg    <= 8'h00;
            tx_cnt_reg   <= 4'h0;
            tx_half_reg  <= 3'h0;
            tx_par_reg   <= 1'b0;
        end else begin
            case (tx_state_reg)
                acs_pkg::TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg    <= txq.rdata;
                        tx_par_reg   <= tx_par_bit;
                        tx_cnt_reg   <= 4'h0;
                        tx_state_reg <= acs_pkg::TX_START;
                    end
                end
                acs_pkg::TX_START: begin
                    if (tx_tick) begin
                        tx_state_reg <= acs_pkg::TX_DATA;
                    end
                end
                acs_pkg::TX_DATA: begin
                    if (tx_tick) begin
                        tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        tx_half_reg <= 3'h0;
                        if (tx_cnt_reg == tx_n - 4'h1) begin
                            tx_state_reg <= parity_en ? acs_pkg::TX_PAR : acs_pkg::TX_STOP;
                        end
                    end
                end
                acs_pkg::TX_PAR: begin
                    if (tx_tick) begin
                        tx_half_reg  <= 3'h0;
                        tx_state_reg <= acs_pkg::TX_STOP;
                    end
                end
                acs_pkg::TX_STOP: begin
                    tx_half_reg <= tx_half_next;
                    if (tx_stop_done) begin
                        tx_state_reg <= acs_pkg::TX_IDLE;
                    end
                end
                default: tx_state_reg <= acs_pkg::TX_IDLE;
            endcase
        end
    end

    logic tx_line;
    always_comb begin
        case (tx_state_reg)
            acs_pkg::TX_START: tx_line = 1'b0;
            acs_pkg::TX_DATA:  tx_line = tx_sh_reg[0];
            acs_pkg::TX_PAR:   tx_line = tx_par_reg;
            default:           tx_line = 1'b1;
        endcase
    end

    // ---------------- receiver ----------------
    acs_pkg::acs_rx_state_e rx_state_reg;
    logic [7:0] rx_sh_reg;
    logic [3:0] rx_cnt_reg;
    logic       rx_pbit_reg;
    logic       rx_mid;
    logic       rx_tick;
    wire  [3:0] rx_n     = bits_of(rx_len);
    wire        rx_on    = rx_enable && !(auto_enable && carrier_detect_pin_n);
    wire        rx_begin = (rx_state_reg == acs_pkg::RX_IDLE) && rx_on && !rxd;
    wire        rx_x1    = (clk_factor == `ACS_FACT_X1);
    wire  [7:0] rx_raw   = rx_sh_reg >> (4'h8 - rx_n);
    wire  [7:0] rx_fill  = ~low_mask(rx_n);
    wire  [7:0] rx_pmask = (parity_en && rx_n < 4'h8) ? (8'h01 << rx_n) : 8'h00;
    wire  [7:0] rx_char  = rx_raw | (rx_fill & ~rx_pmask) | (rx_pbit_reg ? rx_pmask : 8'h00);
    wire        rx_perr  = parity_en && ((^rx_raw) ^ rx_pbit_reg ^ ~parity_even);
    wire        rx_ferr  = !rxd;
    wire        rx_at_stop = (rx_state_reg == acs_pkg::RX_STOP) && rx_mid;
    wire        rx_is_brk  = rx_ferr && (rx_raw == 8'h00);

    // a break char is kept once, without its framing error
    assign rxq.push  = rx_at_stop;
    assign rxq.wdata = {rx_ferr && !rx_is_brk, rx_perr, rx_char};
    assign rxq.pop   = rx_rd;

    acs_bitclk u_rxclk (
        .mclk    (mclk),
        .reset   (reset),
        .restart (rx_begin),
        .factor  (clk_factor),
        .mid     (rx_mid),
        .tick    (rx_tick)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rx_state_reg <= acs_pkg::RX_IDLE;
            rx_sh_reg    <= 8'h00;
            rx_cnt_reg   <= 4'h0;
            rx_pbit_reg  <= 1'b0;
        end else if (!rx_on && rx_state_reg != acs_pkg::RX_BRK) begin
            rx_state_reg <= acs_pkg::RX_IDLE;
        end else begin
            case (rx_state_reg)
                acs_pkg::RX_IDLE: begin
                    rx_cnt_reg  <= 4'h0;
                    rx_pbit_reg <= 1'b0;
                    if (rx_begin) begin
                        rx_state_reg <= acs_pkg::RX_START;
                    end
                end
                acs_pkg::RX_START: begin
                    // at x1 this cell already holds the first data bit
                    if (rx_mid && rx_x1) begin
                        rx_sh_reg    <= {rxd, rx_sh_reg[7:1]};
                        rx_cnt_reg   <= 4'h1;
                        rx_state_reg <= acs_pkg::RX_DATA;
                    end else if (rx_mid) begin
                        rx_state_reg <= rxd ? acs_pkg::RX_IDLE : acs_pkg::RX_DATA;
                    end
                end
                acs_pkg::RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_reg  <= {rxd, rx_sh_reg[7:1]};
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == rx_n - 4'h1) begin
                            rx_state_reg <= parity_en ? acs_pkg::RX_PAR : acs_pkg::RX_STOP;
                        end
                    end
                end
                acs_pkg::RX_PAR: begin
                    if (rx_mid) begin
                        rx_pbit_reg  <= rxd;
                        rx_state_reg <= acs_pkg::RX_STOP;
                    end
                end
                acs_pkg::RX_STOP: begin
                    if (rx_mid) begin
                        rx_state_reg <= rx_is_brk ? acs_pkg::RX_BRK : acs_pkg::RX_IDLE;
                    end
                end
                acs_pkg::RX_BRK: begin
                    if (rxd) begin
                        rx_state_reg <= acs_pkg::RX_IDLE;
                    end
                end
                default: rx_state_reg <= acs_pkg::RX_IDLE;
            endcase
        end
    end

    // ---------------- status and pins ----------------
    wire head_ok   = !rxq.empty;
    wire head_ferr = head_ok && rxq.rdata[`ACS_ENT_FERR];
    wire head_perr = head_ok && rxq.rdata[`ACS_ENT_PERR];
    wire tx_req_w  = tx_thresh ? txq.empty : !txq.full;
    wire rx_req_w  = rx_thresh ? (rxq.count >= `ACS_THRESH_LVL) : head_ok;
    wire sent_w    = tx_idle_now && txq.empty;
    wire perr_w    = head_perr || (rx_parity_err && !error_reset);
    wire ovr_w     = (rxq.push && rxq.full) || (rx_overrun_err && !error_reset);
    wire brk_w     = (rx_at_stop && rx_is_brk) ||
                     (break_flag && !(rx_state_reg == acs_pkg::RX_BRK && rxd));
    wire rts_hold  = auto_enable && !rts_pin_n && !sent_w;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            txd             <= 1'b1;
            rts_pin_n       <= 1'b1;
            dtr_req_pin_n   <= 1'b1;
            tx_space_flag   <= 1'b0;
            tx_intr_req     <= 1'b0;
            all_sent        <= 1'b1;
            rx_avail_flag   <= 1'b0;
            rx_intr_req     <= 1'b0;
            rx_data         <= 8'h00;
            rx_framing_err  <= 1'b0;
            rx_parity_err   <= 1'b0;
            rx_overrun_err  <= 1'b0;
            special_rx_cond <= 1'b0;
            break_flag      <= 1'b0;
            sync_hunt_flag  <= 1'b0;
            carrier_flag    <= 1'b0;
            cts_flag        <= 1'b0;
            line_code       <= `ACS_ENC_NRZ;
        end else begin
            txd             <= send_break ? 1'b0 : tx_line;
            rts_pin_n       <= !(rts_bit || rts_hold);
            dtr_req_pin_n   <= dtr_is_req ? !tx_req_w : !dtr_bit;
            tx_space_flag   <= tx_req_w;
            tx_intr_req     <= tx_req_w;
            all_sent        <= sent_w;
            rx_avail_flag   <= head_ok;
            rx_intr_req     <= rx_req_w;
            rx_data         <= rxq.rdata[`ACS_CHAR_W-1:0];
            rx_framing_err  <= head_ferr;
            rx_parity_err   <= perr_w;
            rx_overrun_err  <= ovr_w;
            special_rx_cond <= head_ferr || (parity_intr_en && perr_w) || ovr_w;
            break_flag      <= brk_w;
            sync_hunt_flag  <= xtal_en ? 1'b0 : !sync_pin_n;
            carrier_flag    <= !carrier_detect_pin_n;
            cts_flag        <= !cts_pin_n;
            line_code       <= rx_x1 ? line_encoding : `ACS_ENC_NRZ;
        end
    end
endmodule
`default_nettype wire

/* acs_channel_sva.sv */
// port checker for the serial channel
`timescale 1ns/1ps
`default_nettype none
module acs_chk (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       xtal_en,
    input wire logic       sync_pin_n,
    input wire logic       dtr_is_req,
    input wire logic       dtr_bit,
    input wire logic [1:0] clk_factor,
    input wire logic [1:0] line_encoding,
    input wire logic       send_break,
    input wire logic       error_reset,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic       tx_space_flag,
    input wire logic       tx_intr_req,
    input wire logic       all_sent,
    input wire logic       rx_avail_flag,
    input wire logic       rx_intr_req,
    input wire logic       rx_parity_err,
    input wire logic       break_flag,
    input wire logic       sync_hunt_flag,
    input wire logic       dtr_req_pin_n,
    input wire logic       carrier_detect_pin_n,
    input wire logic       carrier_flag,
    input wire logic [1:0] line_code
);
    logic [1:0] up_cnt;
    wire        up = (up_cnt == 2'h2);
    // outputs still hold reset values for the first edges
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) up_cnt <= 2'h0;
        else if (!up) up_cnt <= up_cnt + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    AST_TX_SPACE: assert property (tx_space_flag == tx_intr_req)
        else $error("tx space flag and tx request differ");
    AST_RX_INTR: assert property (rx_intr_req |-> rx_avail_flag)
        else $error("rx request without a character");
    AST_BREAK_HOLD: assert property (break_flag && !rxd |=> break_flag)
        else $error("break flag dropped while line low");
    AST_SYNC: assert property (up |->
        sync_hunt_flag == (!$past(xtal_en) && !$past(sync_pin_n)))
        else $error("sync flag wrong");
    AST_DTR: assert property (up && !$past(dtr_is_req) |->
        dtr_req_pin_n == !$past(dtr_bit))
        else $error("ready pin not inverse of ready bit");
    AST_CODE: assert property (up |->
        line_code == (($past(clk_factor) == 2'h0) ? $past(line_encoding) : 2'h0))
        else $error("line code wrong for clock factor");
    AST_ALL_SENT: assert property (!txd && !$past(send_break) |-> !all_sent)
        else $error("all sent while line busy");
    AST_CARRIER: assert property (up |-> carrier_flag == !$past(carrier_detect_pin_n))
        else $error("carrier flag not inverse of carrier pin");
    AST_PERR_LATCH: assert property (rx_parity_err && !error_reset |=> rx_parity_err)
        else $error("parity error not held");
endmodule
bind acs_channel acs_chk u_chk (.mclk, .reset, .xtal_en, .sync_pin_n, .dtr_is_req, .dtr_bit,
    .clk_factor, .line_encoding, .send_break, .error_reset, .rxd, .txd, .tx_space_flag,
    .tx_intr_req, .all_sent, .rx_avail_flag, .rx_intr_req, .rx_parity_err, .break_flag,
    .sync_hunt_flag, .dtr_req_pin_n, .carrier_detect_pin_n, .carrier_flag, .line_code);
`default_nettype wire

/* acs_line_model.sv */
// remote serial terminal on the line side
`timescale 1ns/1ps
`default_nettype none
module acs_line (
    input  wire logic mclk,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'h1;
    task automatic bit_out(input logic v, input int c);
        rxd <= v;
        repeat (c) @(posedge mclk);
    endtask
    // start, data lsb first, parity, one stop, one idle cell
    task automatic send(input logic [7:0] d, input int n, input logic pe,
                        input logic ev, input logic stp, input int f);
        @(posedge mclk);
        bit_out(1'h0, f);
        for (int i = 0; i < n; i++) bit_out(d[i], f);
        if (pe) bit_out(^(d & 8'((1 << n) - 1)) ^ !ev, f);
        bit_out(stp, f);
        bit_out(1'h1, f);
    endtask
    // mid-cell samples: data, parity, first stop
    task automatic catch(input int n, input int f, output logic [9:0] g);
        g = '0;
        for (int k = 0; k < 4000 && txd; k++) @(posedge mclk);
        repeat (f / 2) @(posedge mclk);
        for (int i = 0; i < n + 2; i++) begin
            repeat (f) @(posedge mclk);
            g[i] = txd;
        end
    endtask
endmodule
`default_nettype wire

/* acs_channel_tb.sv */
// bench for the serial channel
`timescale 1ns/1ps
`default_nettype none
module acs_channel_tb;
    logic mclk, reset = 1, parity_en = 0, parity_even = 0, rx_enable = 0, tx_enable = 0;
    logic rts_bit = 0, dtr_bit = 0, xtal_en = 0, tx_wr = 0, rx_rd = 0, error_reset = 0;
    logic rx_thresh = 0, tx_thresh = 0, parity_intr_en = 1, sync_pin_n = 1, rxd, txd;
    logic carrier_detect_pin_n = 0, auto_enable = 0, send_break = 0, dtr_is_req = 0;
    logic cts_pin_n = 0, tx_space_flag, all_sent, rx_avail_flag, rx_intr_req;
    logic rx_framing_err, rx_parity_err, rx_overrun_err, special_rx_cond, break_flag;
    logic [1:0] stop_sel = 2'h3, clk_factor = 2'h1, line_encoding = 2'h0;
    logic [1:0] rx_len = 2'h3, tx_len = 2'h3;
    logic [7:0] tx_wdata = 8'h00, rx_data;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    acs_channel dut (.mclk, .reset, .stop_sel, .parity_en, .parity_even, .clk_factor,
        .line_encoding, .rx_len, .rx_enable, .auto_enable, .tx_len, .tx_enable, .send_break,
        .rts_bit, .dtr_bit, .dtr_is_req, .tx_thresh, .rx_thresh, .parity_intr_en, .xtal_en,
        .tx_wr, .tx_wdata, .rx_rd, .error_reset, .rxd, .cts_pin_n, .carrier_detect_pin_n,
        .sync_pin_n, .txd, .rts_pin_n(), .dtr_req_pin_n(), .tx_space_flag, .tx_intr_req(),
        .all_sent, .rx_avail_flag, .rx_intr_req, .rx_data, .rx_framing_err, .rx_parity_err,
        .rx_overrun_err, .special_rx_cond, .break_flag, .sync_hunt_flag(), .carrier_flag(),
        .cts_flag(), .line_code());
    acs_line model (.mclk, .txd, .rxd);
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] e, input logic fe);
        chk(rx_data, e);
        chk(rx_framing_err, fe);
        @(posedge mclk) rx_rd <= 1'h1;
        @(posedge mclk) rx_rd <= 1'h0;
        w(1);
    endtask
    task automatic t_tx;
        logic [9:0] g;
        logic [7:0] m;
        int n;
        @(posedge mclk) parity_en <= 1'h1;
        parity_even <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 5 : (i == 1) ? 7 : (i == 2) ? 6 : 8;
            m = 8'((1 << n) - 1);
            @(posedge mclk) tx_len <= 2'(i);
            tx_wr <= 1'h1;
            tx_wdata <= 8'h1b;
            @(posedge mclk) tx_wr <= 1'h0;
            model.catch(n, 16, g);
            chk(all_sent, 0);
            chk(g, 10'(8'h1b & m) | (10'(^(8'h1b & m)) << n) | (10'h1 << (n + 1)));
            w(40);
            chk(all_sent, 1);
        end
    endtask
    task automatic t_rx;
        logic [7:0] m;
        int n;
        @(posedge mclk) parity_en <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 5 : (i == 1) ? 7 : (i == 2) ? 6 : 8;
            m = 8'((1 << n) - 1);
            @(posedge mclk) rx_len <= 2'(i);
            clk_factor <= 2'(i % 3 + 1);
            model.send(8'h2c, n, 0, 0, 1, 8 << (i % 3 + 1));
            w(1);
            rd((8'h2c & m) | ~m, 0);
        end
        @(posedge mclk) clk_factor <= 2'h1;
        model.send(8'h81, 8, 0, 0, 0, 16);
        model.send(8'h42, 8, 0, 0, 1, 16);
        w(1);
        chk({rx_framing_err, special_rx_cond}, 2'h3);
        rd(8'h81, 1);
        rd(8'h42, 0);
        @(posedge mclk) rx_len <= 2'h1;
        parity_en <= 1'h1;
        parity_even <= 1'h0;
        model.send(8'h2c, 7, 1, 0, 1, 16);
        model.send(8'h2c, 7, 1, 1, 1, 16);
        w(1);
        chk(rx_parity_err, 0);
        rd(8'h2c, 0);
        chk({rx_parity_err, special_rx_cond}, 2'h3);
        rd(8'hac, 0);
        chk(rx_parity_err, 1);
        @(posedge mclk) error_reset <= 1'h1;
        rx_len <= 2'h3;
        @(posedge mclk) error_reset <= 1'h0;
        w(1);
        chk(rx_parity_err, 0);
    endtask
    task automatic t_fifo;
        @(posedge mclk) rx_thresh <= 1'h1;
        parity_en <= 1'h0;
        for (int i = 0; i < 9; i++) begin
            model.send(8'(i + 1), 8, 0, 0, 1, 16);
            w(1);
            if (i == 2) chk({rx_avail_flag, rx_intr_req}, 2'h2);
            if (i == 3) chk(rx_intr_req, 1);
        end
        chk(rx_overrun_err, 1);
        for (int i = 0; i < 8; i++) rd(8'(i + 1), 0);
        chk(rx_avail_flag, 0);
        @(posedge mclk) error_reset <= 1'h1;
        rx_thresh <= 1'h0;
        @(posedge mclk) error_reset <= 1'h0;
    endtask
    task automatic t_break;
        @(posedge mclk) parity_en <= 1'h1;
        model.bit_out(1'h0, 400);
        chk(break_flag, 1);
        model.bit_out(1'h1, 64);
        chk({break_flag, rx_parity_err}, 2'h1);
        rd(8'h00, 0);
        chk(rx_avail_flag, 0);
    endtask
    task automatic t_thr;
        @(posedge mclk) tx_enable <= 1'h0;
        tx_thresh <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) tx_wr <= 1'h1;
            tx_wdata <= 8'(i);
            @(posedge mclk) tx_wr <= 1'h0;
            w(2);
            chk(tx_space_flag, 0);
            @(posedge mclk) tx_thresh <= 1'h0;
            w(2);
            chk(tx_space_flag, i < 3);
            @(posedge mclk) tx_thresh <= (i < 3);
        end
        auto_enable <= 1'h1;
        cts_pin_n <= 1'h1;
        carrier_detect_pin_n <= 1'h1;
        tx_enable <= 1'h1;
        model.send(8'h55, 8, 1, 0, 1, 16);
        w(1);
        chk(tx_space_flag, 0);
        chk(rx_avail_flag, 0);
        @(posedge mclk) cts_pin_n <= 1'h0;
        carrier_detect_pin_n <= 1'h0;
        w(1000);
        chk(all_sent, 1);
        @(posedge mclk) auto_enable <= 1'h0;
    endtask
    task automatic t_pins;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk) clk_factor <= 2'(i);
            line_encoding <= 2'(i + 2);
            dtr_bit <= i[0];
            rts_bit <= i[1];
            sync_pin_n <= i[0];
            xtal_en <= i[2];
            tx_thresh <= i[1];
            carrier_detect_pin_n <= i[2];
            w(3);
        end
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk) tx_enable <= 1'h1;
        rx_enable <= 1'h1;
        w(2);
        chk(tx_space_flag, 1);
        t_tx();
        t_rx();
        t_fifo();
        t_break();
        t_thr();
        t_pins();
        stop_test();
    end
endmodule
`default_nettype wire
